// *** hw/load_store_address_unit.sv ***
// load/store execution: address forming, base writeback, extension, legality
// assumes a memory port on the same clock that holds each request until mem_ack
//
// Summary of operation
// - offset form accesses base plus or minus immediate; base unchanged.
// - pre-indexed accesses base plus or minus offset and writes it back.
// - post-indexed accesses at base, then writes base plus or minus offset.
// - zero immediate offset makes the base itself the access address.
// - single transfers: offset form -255..4095, indexed forms -255..255.
// - two-word transfers take only multiples of four within -1020..1020.
// - unsigned byte and halfword loads zero-extend; stores write low width only.
// - signed byte and halfword loads sign-extend; signed stores are illegal.
// - register form adds offset register shifted left 0..3, no writeback.
// - word load into program counter branches to value with bit 0 cleared.
// - condition flags never change for these transfers.
// - stack pointer or program counter destination word only; pair loads need distinct registers.
// - indexed forms need base distinct from both transfer registers.
// - immediate stores reject program counter base or source; stack pointer word only, or as second source of a pair.
// - register form rejects program counter base, stack pointer or counter offset.
// - register form: stack pointer word only, program counter word load only.
`timescale 1ns/1ns
`default_nettype none

module load_store_address_unit
	import ldst_pkg::*;
(
	input  wire logic         clock,
	input  wire logic         rst,
	input  wire logic         req_valid,
	input  wire ldst_req_s    req_in,
	output logic              req_ready,
	output mem_req_s          mem_out,
	input  wire logic         mem_ack,
	input  wire word_t        mem_rdata,
	output ldst_result_s      result,
	output logic              flags_we
);

	// ****************************************************************
	// state
	// ****************************************************************
	// result and memory request are registered so every output comes from a flop
	lsu_state_e   state_ff,  nxt_state;
	ldst_req_s    req_ff,    nxt_req;
	mem_req_s     mem_ff,    nxt_mem;
	ldst_result_s res_ff,    nxt_res;
	word_t        acc_addr_ff, nxt_acc_addr;
	word_t        wb_addr_ff,  nxt_wb_addr;
	logic         ready_ff,    nxt_ready;
	logic         flags_we_ff;

	assign req_ready = ready_ff;
	assign mem_out   = mem_ff;
	assign result    = res_ff;
	assign flags_we  = flags_we_ff;

	// ****************************************************************
	// helpers
	// ****************************************************************
	// both special registers are barred together in several legality checks
	function automatic logic is_sp_or_pc(input reg_num_t r);
		is_sp_or_pc = (r == STACK_POINTER_NUM) || (r == PROGRAM_COUNTER_NUM);
	endfunction

	// little-endian lane pick, then zero or sign extension
	function automatic word_t extend_load(input word_t data, input logic [LANE_W-1:0] lane, input xfer_size_e sz);
		word_t shifted;
		shifted = data >> ({3'h0, lane} * BYTE_W);
		case (sz)
			SZ_BYTE:                 extend_load = {{(XLEN-BYTE_W){1'b0}}, shifted[BYTE_W-1:0]};
			SZ_HALF:                 extend_load = {{(XLEN-HALF_W){1'b0}}, shifted[HALF_W-1:0]};
			SZ_SIGNED_BYTE_TYPE:     extend_load = {{(XLEN-BYTE_W){shifted[BYTE_W-1]}}, shifted[BYTE_W-1:0]};
			SZ_SIGNED_HALFWORD_TYPE: extend_load = {{(XLEN-HALF_W){shifted[HALF_W-1]}}, shifted[HALF_W-1:0]};
			default:                 extend_load = data;
		endcase
	endfunction

	function automatic logic [3:0] size_be(input xfer_size_e sz);
		case (sz)
			SZ_BYTE, SZ_SIGNED_BYTE_TYPE:         size_be = BE_BYTE;
			SZ_HALF, SZ_SIGNED_HALFWORD_TYPE:     size_be = BE_HALF;
			default:                              size_be = BE_WORD;
		endcase
	endfunction

	// ****************************************************************
	// legality of the incoming request
	// ****************************************************************
	logic        illegal;
	logic        is_pair;
	logic        is_word;
	logic        is_signed;
	logic        indexed;
	logic [11:0] imm_limit;

	always_comb begin
		is_pair   = (req_in.size == SZ_PAIR);
		is_word   = (req_in.size == SZ_WORD);
		is_signed = (req_in.size == SZ_SIGNED_BYTE_TYPE) || (req_in.size == SZ_SIGNED_HALFWORD_TYPE);
		indexed   = (req_in.mode == MODE_PRE) || (req_in.mode == MODE_POST);
		illegal   = 1'b0;
		// limits are magnitudes; add_offset carries the direction
		// each check below only ever raises illegal, so their order is free
		if (is_pair)
			imm_limit = IMM_MAX_PAIR;
		else if (req_in.mode == MODE_OFFSET && req_in.add_offset)
			imm_limit = IMM_MAX_OFFSET;
		else
			imm_limit = IMM_MAX_INDEXED;
		if (!req_in.is_load && is_signed)
			illegal = 1'b1;
		if (req_in.mode == MODE_REG) begin
			if (is_pair)
				illegal = 1'b1;
			if (req_in.base_reg == PROGRAM_COUNTER_NUM || is_sp_or_pc(req_in.offset_reg))
				illegal = 1'b1;
			if (req_in.transfer_reg == STACK_POINTER_NUM && !is_word)
				illegal = 1'b1;
			if (req_in.transfer_reg == PROGRAM_COUNTER_NUM && !(is_word && req_in.is_load))
				illegal = 1'b1;
		end else begin
			if (req_in.imm > imm_limit)
				illegal = 1'b1;
			if (is_pair && (req_in.imm[1:0] & PAIR_ALIGN_MASK) != 2'h0)
				illegal = 1'b1;
			if (req_in.is_load) begin
				if (is_sp_or_pc(req_in.transfer_reg) && !is_word)
					illegal = 1'b1;
				if (is_pair && (req_in.transfer_reg == req_in.second_transfer_reg
						|| is_sp_or_pc(req_in.second_transfer_reg)))
					illegal = 1'b1;
			end else begin
				if (req_in.base_reg == PROGRAM_COUNTER_NUM || req_in.transfer_reg == PROGRAM_COUNTER_NUM)
					illegal = 1'b1;
				if (req_in.transfer_reg == STACK_POINTER_NUM && !is_word)
					illegal = 1'b1;
				if (is_pair && req_in.second_transfer_reg == PROGRAM_COUNTER_NUM)
					illegal = 1'b1;
			end
			if (indexed && (req_in.base_reg == req_in.transfer_reg
					|| (is_pair && req_in.base_reg == req_in.second_transfer_reg)))
				illegal = 1'b1;
		end
		// a conditional branch-load placed mid-block cannot be honoured safely
		if (req_in.is_load && is_word && req_in.transfer_reg == PROGRAM_COUNTER_NUM
				&& req_in.in_conditional_block && !req_in.last_in_block)
			illegal = 1'b1;
	end

	// ****************************************************************
	// address forming
	// ****************************************************************
	word_t offset_val;
	word_t indexed_sum;
	word_t access_addr;

	always_comb begin
		if (req_in.mode == MODE_REG)
			offset_val = req_in.offset_val << req_in.left_shift_amount;
		else
			offset_val = {{(XLEN-$bits(req_in.imm)){1'b0}}, req_in.imm};
		// a zero immediate leaves the sum equal to the base
		if (req_in.mode == MODE_REG || req_in.add_offset)
			indexed_sum = req_in.base_val + offset_val;
		else
			indexed_sum = req_in.base_val - offset_val;
		if (req_in.mode == MODE_POST)
			access_addr = req_in.base_val;
		else
			access_addr = indexed_sum;
	end

	// ****************************************************************
	// sequencer: next values
	// ****************************************************************
	word_t              load_val;
	logic [LANE_W-1:0]  lane;
	logic               pc_load;

	always_comb begin
		nxt_state    = state_ff;
		nxt_req      = req_ff;
		nxt_mem      = mem_ff;
		nxt_res      = res_ff;
		nxt_acc_addr = acc_addr_ff;
		nxt_wb_addr  = wb_addr_ff;
		nxt_ready    = ready_ff;
		// a result pulse lasts one cycle; its data fields hold until the next take
		nxt_res.valid = 1'b0;
		lane         = acc_addr_ff[LANE_W-1:0];
		load_val     = extend_load(mem_rdata, lane, req_ff.size);
		// the low bit of a loaded branch value is dropped, never checked
		pc_load      = req_ff.is_load && req_ff.transfer_reg == PROGRAM_COUNTER_NUM;
		case (state_ff)
			ST_IDLE: begin
				if (req_valid && ready_ff) begin
					nxt_req      = req_in;
					nxt_acc_addr = access_addr;
					nxt_wb_addr  = indexed_sum;
					nxt_res      = '0;
					nxt_res.base_num = req_in.base_reg;
					if (illegal) begin
						// nothing reaches memory and ready stays high
						nxt_res.valid     = 1'b1;
						nxt_res.undefined = 1'b1;
					end else begin
						nxt_ready     = 1'b0;
						nxt_mem.req   = 1'b1;
						nxt_mem.write = !req_in.is_load;
						nxt_mem.addr  = access_addr;
						nxt_mem.be    = size_be(req_in.size) << access_addr[LANE_W-1:0];
						// stores shift the whole value onto its lanes; the byte enables keep only the low width
						nxt_mem.wdata = req_in.store_val << ({3'h0, access_addr[LANE_W-1:0]} * BYTE_W);
						// a word pair always moves whole words; lanes play no part
						if (is_pair) begin
							nxt_mem.be    = BE_WORD;
							nxt_mem.wdata = req_in.store_val;
						end
						nxt_state     = ST_FIRST;
					end
				end
			end
			ST_FIRST: begin
				if (mem_ack) begin
					nxt_res.rd_num = req_ff.transfer_reg;
					if (req_ff.is_load) begin
						if (pc_load) begin
							nxt_res.branch        = 1'b1;
							nxt_res.branch_target = load_val & BRANCH_CLR_MASK;
						end else begin
							nxt_res.rd_we   = 1'b1;
							nxt_res.rd_data = load_val;
						end
					end
					if (req_ff.size == SZ_PAIR) begin
						// byte enables stay whole-word from the first beat
						nxt_mem.addr  = acc_addr_ff + PAIR_STEP;
						nxt_mem.wdata = req_ff.store_val2;
						nxt_state     = ST_SECOND;
					end else begin
						nxt_mem.req   = 1'b0;
						nxt_res.valid = 1'b1;
						nxt_res.base_we   = req_ff.mode == MODE_PRE || req_ff.mode == MODE_POST;
						nxt_res.base_data = wb_addr_ff;
						nxt_ready     = 1'b1;
						nxt_state     = ST_IDLE;
					end
				end
			end
			// the second word is never extended: a pair moves whole words
			ST_SECOND: begin
				if (mem_ack) begin
					nxt_mem.req       = 1'b0;
					nxt_res.rd2_num   = req_ff.second_transfer_reg;
					nxt_res.rd2_we    = req_ff.is_load;
					nxt_res.rd2_data  = mem_rdata;
					nxt_res.valid     = 1'b1;
					nxt_res.base_we   = req_ff.mode == MODE_PRE || req_ff.mode == MODE_POST;
					nxt_res.base_data = wb_addr_ff;
					nxt_ready         = 1'b1;
					nxt_state         = ST_IDLE;
				end
			end
			// unused encodings fall back to idle with the memory port quiet
			default: begin
				nxt_state = ST_IDLE;
				nxt_mem   = '0;
				nxt_ready = 1'b1;
			end
		endcase
	end

	// ****************************************************************
	// sequencer: registers
	// ****************************************************************
	always_ff @(posedge clock) begin
		if (rst) begin
			state_ff    <= ST_IDLE;
			req_ff      <= '0;
			mem_ff      <= '0;
			res_ff      <= '0;
			acc_addr_ff <= '0;
			wb_addr_ff  <= '0;
			ready_ff    <= 1'b1;
			flags_we_ff <= 1'b0;
		end else begin
			state_ff    <= nxt_state;
			req_ff      <= nxt_req;
			mem_ff      <= nxt_mem;
			res_ff      <= nxt_res;
			acc_addr_ff <= nxt_acc_addr;
			wb_addr_ff  <= nxt_wb_addr;
			ready_ff    <= nxt_ready;
			// these transfers never touch the flags, so the strobe stays low
			flags_we_ff <= 1'b0;
		end
	end

endmodule

`default_nettype wire

// *** shared/ldst_pkg.sv ***
// shared types and constants of the load/store address unit
// assumes a 32-bit core with sixteen general registers, little-endian memory
package ldst_pkg;

	// ****************************************************************
	// widths and register numbers
	// ****************************************************************
	localparam int XLEN   = 32;
	localparam int LANE_W = 2;
	localparam int BYTE_W = 8;
	localparam int HALF_W = 16;
	typedef logic [3:0]      reg_num_t;
	typedef logic [XLEN-1:0] word_t;
	localparam reg_num_t STACK_POINTER_NUM   = 4'hD;
	localparam reg_num_t PROGRAM_COUNTER_NUM = 4'hF;

	// ****************************************************************
	// immediate offset limits, magnitude with a separate add/subtract bit
	// ****************************************************************
	localparam logic [11:0] IMM_MAX_OFFSET  = 12'hFFF;
	localparam logic [11:0] IMM_MAX_INDEXED = 12'h0FF;
	localparam logic [11:0] IMM_MAX_PAIR    = 12'h3FC;
	localparam logic [1:0]  PAIR_ALIGN_MASK = 2'h3;
	localparam word_t       PAIR_STEP       = 32'h0000_0004;
	localparam word_t       BRANCH_CLR_MASK = 32'hFFFF_FFFE;

	// ****************************************************************
	// byte enables for each access width
	// ****************************************************************
	localparam logic [3:0] BE_BYTE = 4'h1;
	localparam logic [3:0] BE_HALF = 4'h3;
	localparam logic [3:0] BE_WORD = 4'hF;

	// ****************************************************************
	// modes and states
	// ****************************************************************
	typedef enum logic [2:0] {SZ_WORD, SZ_BYTE, SZ_SIGNED_BYTE_TYPE, SZ_HALF, SZ_SIGNED_HALFWORD_TYPE, SZ_PAIR} xfer_size_e;
	typedef enum logic [1:0] {MODE_OFFSET, MODE_PRE, MODE_POST, MODE_REG} addr_mode_e;
	typedef enum logic [1:0] {ST_IDLE, ST_FIRST, ST_SECOND} lsu_state_e;

	// ****************************************************************
	// carriers
	// ****************************************************************
	typedef struct packed {
		logic       is_load;
		xfer_size_e size;
		addr_mode_e mode;
		logic       add_offset;
		logic [11:0] imm;
		logic [1:0] left_shift_amount;
		reg_num_t   base_reg;
		reg_num_t   transfer_reg;
		reg_num_t   second_transfer_reg;
		reg_num_t   offset_reg;
		word_t      base_val;
		word_t      offset_val;
		word_t      store_val;
		word_t      store_val2;
		logic       in_conditional_block;
		logic       last_in_block;
	} ldst_req_s;

	typedef struct packed {
		logic       req;
		logic       write;
		word_t      addr;
		word_t      wdata;
		logic [3:0] be;
	} mem_req_s;

	typedef struct packed {
		logic     valid;
		logic     undefined;
		logic     rd_we;
		reg_num_t rd_num;
		word_t    rd_data;
		logic     rd2_we;
		reg_num_t rd2_num;
		word_t    rd2_data;
		logic     base_we;
		reg_num_t base_num;
		word_t    base_data;
		logic     branch;
		word_t    branch_target;
	} ldst_result_s;

endpackage

// *** test/ldst_checker.sv ***
// concurrent checks on the load/store unit ports
// assumes binding into load_store_address_unit
`timescale 1ns/1ns
`default_nettype none
module ldst_checker
	import ldst_pkg::*;
(
	input  wire logic         clock,
	input  wire logic         rst,
	input  wire logic         req_valid,
	input  wire ldst_req_s    req_in,
	input  wire logic         req_ready,
	input  wire mem_req_s     mem_out,
	input  wire logic         mem_ack,
	input  wire word_t        mem_rdata,
	input  wire ldst_result_s result,
	input  wire logic         flags_we
);
	// ****
	// captured request and its addresses
	// ****
	ldst_req_s cap_ff;
	ldst_req_s nxt_cap;
	word_t     off;
	word_t     ea;
	word_t     acc;
	logic      take;
	assign take = req_valid && req_ready;
	always_comb begin
		nxt_cap = take ? req_in : cap_ff;
	end
	always_ff @(posedge clock) begin
		cap_ff <= nxt_cap;
	end
	assign off = cap_ff.mode == MODE_REG ? cap_ff.offset_val << cap_ff.left_shift_amount : {20'h0, cap_ff.imm};
	assign ea  = (cap_ff.add_offset || cap_ff.mode == MODE_REG) ? cap_ff.base_val + off : cap_ff.base_val - off;
	assign acc = cap_ff.mode == MODE_POST ? cap_ff.base_val : ea;
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	property p_addr; $rose(mem_out.req) |-> mem_out.addr == acc; endproperty
	a_addr: assert property (p_addr) else $error("access address wrong");
	property p_wb;
		result.valid && !result.undefined |-> result.base_we == (cap_ff.mode inside {MODE_PRE, MODE_POST})
			&& (!result.base_we || result.base_data == ea);
	endproperty
	a_wb: assert property (p_wb) else $error("base writeback wrong");
	property p_pair; mem_out.req && mem_ack && cap_ff.size == SZ_PAIR && mem_out.addr == acc
		|=> mem_out.req && mem_out.addr == acc + PAIR_STEP && mem_out.be == BE_WORD; endproperty
	a_pair: assert property (p_pair) else $error("second word access wrong");
	property p_undef; result.valid && result.undefined
		|-> !result.rd_we && !result.rd2_we && !result.base_we && !result.branch && !mem_out.req; endproperty
	a_undef: assert property (p_undef) else $error("undefined op had side effects");
	property p_zero; result.valid && !result.undefined && cap_ff.is_load && cap_ff.size inside {SZ_BYTE, SZ_HALF}
		|-> result.rd_data[31:16] == 16'h0 && (cap_ff.size == SZ_HALF || result.rd_data[15:8] == 8'h0); endproperty
	a_zero: assert property (p_zero) else $error("zero extension wrong");
	property p_sign; result.valid && !result.undefined && cap_ff.size == SZ_SIGNED_BYTE_TYPE
		|-> result.rd_data[31:8] == {24{result.rd_data[7]}}; endproperty
	a_sign: assert property (p_sign) else $error("sign extension wrong");
	property p_sstore; take && !req_in.is_load && req_in.size inside {SZ_SIGNED_BYTE_TYPE, SZ_SIGNED_HALFWORD_TYPE}
		|=> result.valid && result.undefined; endproperty
	a_sstore: assert property (p_sstore) else $error("signed store accepted");
	property p_pcst; take && !req_in.is_load && req_in.mode != MODE_REG && (req_in.base_reg == PROGRAM_COUNTER_NUM
		|| req_in.transfer_reg == PROGRAM_COUNTER_NUM) |=> result.valid && result.undefined; endproperty
	a_pcst: assert property (p_pcst) else $error("store with counter accepted");
	property p_branch; result.valid && result.branch
		|-> result.branch_target[0] == 1'b0 && !result.rd_we && cap_ff.transfer_reg == PROGRAM_COUNTER_NUM; endproperty
	a_branch: assert property (p_branch) else $error("branch result wrong");
	property p_flags; !flags_we; endproperty
	a_flags: assert property (p_flags) else $error("flags written");
	c_branch: cover property (result.valid && result.branch);
	c_undef: cover property (result.valid && result.undefined);
	c_pair: cover property (mem_out.req && mem_ack && cap_ff.size == SZ_PAIR);
endmodule
bind load_store_address_unit ldst_checker chk (.clock, .rst, .req_valid, .req_in, .req_ready, .mem_out, .mem_ack,
	.mem_rdata, .result, .flags_we);
`default_nettype wire

// *** test/ldst_mem_model.sv ***
// memory system model facing the load/store unit
// assumes 16 words aliased over all addresses; tb preloads mem
`timescale 1ns/1ns
`default_nettype none
module ldst_mem_model
	import ldst_pkg::*;
(
	input  wire logic     clock,
	input  wire logic     rst,
	input  wire mem_req_s mem_out,
	input  wire logic [1:0] wait_cycles,
	output logic          mem_ack,
	output word_t         mem_rdata
);
	// ****
	// storage and answer
	// ****
	word_t      mem [16];
	logic [1:0] cnt_ff;
	always @(posedge clock) begin
		if (rst || !mem_out.req || mem_ack) begin
			cnt_ff <= 2'h0;
		end else begin
			cnt_ff <= cnt_ff + 2'h1;
		end
		for (int i = 0; i < 4; i++) begin
			if (mem_out.req && mem_ack && mem_out.write && mem_out.be[i]) begin
				mem[mem_out.addr[5:2]][8*i+:8] <= mem_out.wdata[8*i+:8];
			end
		end
	end
	assign mem_ack = mem_out.req && cnt_ff == wait_cycles;
	// read data is only good with ack; otherwise inverted so stale use shows
	assign mem_rdata = mem_ack ? mem[mem_out.addr[5:2]] : ~mem[mem_out.addr[5:2]];
endmodule
`default_nettype wire

// *** test/test_load_store_address_unit.sv ***
// self-checking bench of the load/store unit with a memory model
// assumes mem_ack answers combinationally after wait_cycles
`timescale 1ns/1ns
`default_nettype none
module test_load_store_address_unit
	import ldst_pkg::*;
;
	logic         clock;
	logic         rst;
	logic         req_valid;
	ldst_req_s    req_in;
	logic         req_ready;
	mem_req_s     mem_out;
	logic         mem_ack;
	word_t        mem_rdata;
	ldst_result_s result;
	ldst_result_s res;
	logic         flags_we;
	logic [1:0]   wait_cycles;
	logic         busy;
	int           errors;
	int           n_compared;
	int           cycles;
	load_store_address_unit dut (.clock, .rst, .req_valid, .req_in, .req_ready, .mem_out, .mem_ack, .mem_rdata,
		.result, .flags_we);
	ldst_mem_model mem (.clock, .rst, .mem_out, .wait_cycles, .mem_ack, .mem_rdata);
	always #5 clock = ~clock;
	always @(posedge clock) begin
		cycles++;
		if (cycles == 3000) begin
			errors++;
			stop_test();
		end
	end
	// ****
	// shared tasks
	// ****
	task automatic chk(input string what, input word_t exp, input word_t got);
		n_compared++;
		if (got !== exp) begin
			errors++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask
	function automatic ldst_req_s mk(logic ld, xfer_size_e sz, addr_mode_e md, logic add, logic [11:0] imm, word_t bv);
		mk = '0;
		mk.is_load = ld;
		mk.size = sz;
		mk.mode = md;
		mk.add_offset = add;
		mk.imm = imm;
		mk.base_val = bv;
		mk.base_reg = 4'h1;
		mk.transfer_reg = 4'h2;
		mk.second_transfer_reg = 4'h3;
		mk.offset_reg = 4'h4;
	endfunction
	// next request may go in the very cycle the result shows
	task automatic run(input ldst_req_s r);
		req_in = r;
		req_valid = 1'b1;
		@(posedge clock);
		#1 req_valid = 1'b0;
		busy = req_ready;
		for (int n = 0; n < 20 && result.valid !== 1'b1; n++) begin
			@(posedge clock);
			#1;
		end
		res = result;
		chk("result valid", 32'h1, {31'h0, result.valid});
		chk("ready at result", 32'h1, {31'h0, req_ready});
		chk("flags write", 32'h0, {31'h0, flags_we});
	endtask
	task automatic ok(input ldst_req_s r, input word_t data, input logic wb, input word_t base);
		run(r);
		chk("undefined", 32'h0, {31'h0, res.undefined});
		chk("base write", {31'h0, wb}, {31'h0, res.base_we});
		chk("ready while busy", 32'h0, {31'h0, busy});
		if (r.is_load && r.transfer_reg != PROGRAM_COUNTER_NUM) chk("load data", data, res.rd_data);
		if (wb) chk("base value", base, res.base_data);
	endtask
	task automatic bad(input ldst_req_s r);
		run(r);
		chk("undefined", 32'h1, {31'h0, res.undefined});
		chk("no writeback", 32'h0, {30'h0, res.rd_we, res.base_we});
		chk("ready after refusal", 32'h1, {31'h0, busy});
	endtask
	// ****
	// scenarios
	// ****
	task automatic t_offset();
		ok(mk(1, SZ_WORD, MODE_OFFSET, 1, 12'h004, 32'h100), 32'h8070_F001, 0, 0);
		ok(mk(1, SZ_BYTE, MODE_OFFSET, 1, 12'h000, 32'h105), 32'h0000_00F0, 0, 0);
		ok(mk(1, SZ_HALF, MODE_OFFSET, 1, 12'hFFF, 32'h1), 32'h0000_F000, 0, 0);
		bad(mk(1, SZ_WORD, MODE_OFFSET, 0, 12'h100, 32'h400));
		$display("t_offset done");
	endtask
	task automatic t_pre();
		ldst_req_s r;
		ok(mk(1, SZ_SIGNED_HALFWORD_TYPE, MODE_PRE, 0, 12'h0FF, 32'h14B), 32'hFFFF_F003, 1, 32'h4C);
		ok(mk(1, SZ_SIGNED_BYTE_TYPE, MODE_PRE, 1, 12'h0FF, 32'h4), 32'hFFFF_FF80, 1, 32'h103);
		bad(mk(1, SZ_WORD, MODE_PRE, 1, 12'h100, 32'h0));
		r = mk(0, SZ_WORD, MODE_PRE, 1, 12'h4, 32'h0);
		r.base_reg = 4'h2;
		bad(r);
		$display("t_pre done");
	endtask
	task automatic t_post();
		ldst_req_s r;
		r = mk(0, SZ_BYTE, MODE_POST, 1, 12'h4, 32'h82);
		r.store_val = 32'h1234_5655;
		ok(r, 0, 1, 32'h86);
		chk("stored byte", 32'h8055_F000, mem.mem[0]);
		bad(mk(0, SZ_SIGNED_BYTE_TYPE, MODE_POST, 1, 12'h4, 32'h0));
		r = mk(0, SZ_HALF, MODE_REG, 0, 12'h0, 32'h18);
		r.offset_val = 32'h1;
		r.left_shift_amount = 2'h1;
		r.store_val = 32'hDEAD_1234;
		ok(r, 0, 0, 0);
		chk("stored half", 32'h1234_F006, mem.mem[6]);
		ok(mk(1, SZ_SIGNED_HALFWORD_TYPE, MODE_OFFSET, 1, 12'h01A, 32'h0), 32'h0000_1234, 0, 0);
		$display("t_post done");
	endtask
	task automatic t_reg();
		ldst_req_s r;
		for (int k = 0; k < 4; k++) begin
			r = mk(1, SZ_WORD, MODE_REG, 0, 12'h0, 32'h100);
			r.offset_val = 32'h4;
			r.left_shift_amount = 2'(k);
			ok(r, 32'h8070_F000 | (32'h1 << k), 0, 0);
		end
		r.base_reg = PROGRAM_COUNTER_NUM;
		bad(r);
		r = mk(1, SZ_WORD, MODE_REG, 0, 12'h0, 32'h0);
		r.offset_reg = STACK_POINTER_NUM;
		bad(r);
		r.offset_reg = PROGRAM_COUNTER_NUM;
		bad(r);
		r = mk(1, SZ_BYTE, MODE_REG, 0, 12'h0, 32'h0);
		r.transfer_reg = STACK_POINTER_NUM;
		bad(r);
		r = mk(0, SZ_WORD, MODE_REG, 0, 12'h0, 32'h0);
		r.transfer_reg = PROGRAM_COUNTER_NUM;
		bad(r);
		$display("t_reg done");
	endtask
	task automatic t_pair();
		ldst_req_s r;
		wait_cycles = 2'h2;
		run(mk(1, SZ_PAIR, MODE_OFFSET, 1, 12'h3FC, 32'h0));
		chk("first word", 32'h8070_F00F, res.rd_data);
		chk("second word", 32'h8055_F000, res.rd2_data);
		r = mk(0, SZ_PAIR, MODE_POST, 0, 12'h3FC, 32'h40);
		r.store_val = 32'hAAAA_0001;
		r.store_val2 = 32'hBBBB_0002;
		ok(r, 0, 1, 32'hFFFF_FC44);
		chk("first stored", 32'hAAAA_0001, mem.mem[0]);
		chk("second stored", 32'hBBBB_0002, mem.mem[1]);
		bad(mk(1, SZ_PAIR, MODE_OFFSET, 1, 12'h102, 32'h0));
		bad(mk(1, SZ_PAIR, MODE_PRE, 1, 12'h400, 32'h0));
		r = mk(1, SZ_PAIR, MODE_OFFSET, 1, 12'h8, 32'h0);
		r.second_transfer_reg = 4'h2;
		bad(r);
		wait_cycles = 2'h0;
		$display("t_pair done");
	endtask
	task automatic t_branch();
		ldst_req_s r;
		r = mk(1, SZ_WORD, MODE_OFFSET, 1, 12'h0, 32'h10C);
		r.transfer_reg = PROGRAM_COUNTER_NUM;
		r.in_conditional_block = 1'b1;
		r.last_in_block = 1'b1;
		ok(r, 0, 0, 0);
		chk("branch", 32'h1, {31'h0, res.branch});
		chk("branch target", 32'h8070_F002, res.branch_target);
		r.last_in_block = 1'b0;
		bad(r);
		r.size = SZ_BYTE;
		r.in_conditional_block = 1'b0;
		bad(r);
		r = mk(0, SZ_WORD, MODE_OFFSET, 1, 12'h0, 32'h0);
		r.base_reg = PROGRAM_COUNTER_NUM;
		bad(r);
		r = mk(0, SZ_HALF, MODE_OFFSET, 1, 12'h0, 32'h0);
		r.transfer_reg = STACK_POINTER_NUM;
		bad(r);
		$display("t_branch done");
	endtask
	task automatic stop_test();
		$display("compared %0d mismatches %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	initial begin
		clock = 1'b0;
		rst = 1'b1;
		req_valid = 1'b0;
		req_in = '0;
		wait_cycles = 2'h0;
		for (int i = 0; i < 16; i++) mem.mem[i] = 32'h8070_F000 | word_t'(i);
		repeat (12) @(posedge clock);
		#1 rst = 1'b0;
		t_offset();
		t_pre();
		t_post();
		t_reg();
		t_pair();
		t_branch();
		stop_test();
	end
endmodule
`default_nettype wire
